// ---- test/adcoc_link_sva.sv ----
// Assertions on the serial link between the host and the offset device.
`timescale 1ns/1ps
`default_nettype none
module adcoc_link_sva
   import adcoc_pkg::*;
(
   input wire logic clk_sys_in, // Clock.
   input wire logic rst_n_in, // Reset, active low.
   input wire logic sck, // Serial clock.
   input wire logic csb_n, // Chip select, active low.
   input wire logic sdi, // Host to device data.
   input wire logic sdo, // Device to host data.
   input wire logic clk_active // Device clock running.
);
   // ---------------------------------------------------------------
   // Frame decoding
   // ---------------------------------------------------------------
   logic sck_q, csb_q, act_q;
   logic [5:0] fall_q;
   logic [7:0] cmd_q;
   logic [9:0] gap_q;
   wire fall = !csb_n && sck_q && !sck;
   wire ofs_wr = !cmd_q[7] && cmd_q[3:1] == 3'h6;
   always_ff @(posedge clk_sys_in) begin
      sck_q <= sck | !rst_n_in;
      csb_q <= csb_n | !rst_n_in;
   end
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in || csb_n) fall_q <= 6'h00;
      else if (fall) fall_q <= fall_q + 6'h01;
   end
   always_ff @(posedge clk_sys_in) begin
      if (fall && fall_q < 6'h08) cmd_q <= {cmd_q[6:0], sdi};
      if (csb_q && !csb_n) act_q <= clk_active;
   end
   // The gap count saturates, so a long idle never wraps into a false short gap.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) gap_q <= 10'h3FF;
      else if (!csb_q && csb_n && ofs_wr) gap_q <= 10'h000;
      else if (gap_q != 10'h3FF) gap_q <= gap_q + 10'h001;
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   sequence low_half;
      !sck [*4];
   endsequence
   sequence high_half;
      sck [*4];
   endsequence
   idle_clock_a: assert property (csb_n |-> sck)
      else $error("serial clock low while deselected");
   low_half_a: assert property ($fell(sck) |-> low_half)
      else $error("serial clock low phase too short");
   high_half_a: assert property ($rose(sck) && !csb_n |-> high_half)
      else $error("serial clock high phase too short");
   frame_len_a: assert property ($rose(csb_n) |-> fall_q == 6'h20)
      else $error("frame is not 32 bits");
   sdi_hold_a: assert property (!csb_n && !sck && !sck_q |-> $stable(sdi))
      else $error("host data moved while clock low");
   cmd_pad_a: assert property (fall && fall_q == 6'h08 |-> cmd_q[6:4] == 3'h0)
      else $error("command padding not zero");
   write_clock_a: assert property ($rose(csb_n) && ofs_wr |-> act_q)
      else $error("offset written with device clock stopped");
   settle_gap_a: assert property (csb_q && !csb_n |-> gap_q >= ADCOC_SETTLE_CYCLES - 2)
      else $error("frame started inside settle gap");
endmodule : adcoc_link_sva
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for host and offset device joined by their link.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import adcoc_pkg::*;
;
   logic clk_sys_in, rst_n_in, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic int_clk_run_in, cal_load_in, cal_sel_in, raw_valid_in, raw_sel_in;
   logic [23:0] cal_value_in, raw_data_in, out_data_out;
   logic out_valid_out, auto_sleep_out;
   int fail_count, tests_run, i;
   int cyc = 0;
   logic [3:0] ra [4] = '{4'hC, 4'hD, 4'hC, 4'hD};
   logic [23:0] rc [4] = '{24'h000004, 24'hFFFFFC, 24'h7FFFFF, 24'hFFFFF0};
   logic [23:0] rr [4] = '{24'h100000, 24'h7FFFFE, 24'h800000, 24'h000010};
   logic [23:0] re [4] = '{24'h0FFFFC, 24'h7FFFFF, 24'h800000, 24'h000020};
   adcoc_link_if u_link();
   adcoc_host u_adcoc_host(.clk_sys_in, .rst_n_in, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .link(u_link));
   adcoc_device #(.RES_BITS(24)) u_adcoc_device(.clk_sys_in, .rst_n_in, .link(u_link),
      .int_clk_run_in, .cal_load_in, .cal_sel_in, .cal_value_in, .raw_valid_in,
      .raw_data_in, .raw_sel_in, .out_valid_out, .out_data_out, .auto_sleep_out);
   adcoc_link_sva u_adcoc_link_sva(.clk_sys_in, .rst_n_in, .sck(u_link.sck),
      .csb_n(u_link.csb_n), .sdi(u_link.sdi), .sdo(u_link.sdo),
      .clk_active(u_link.clk_active));
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   // Every run should finish well inside this; a hang lands here.
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         give_verdict();
      end
   end
   task give_verdict();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      @(posedge clk_sys_in);
      while (pready !== 1'b1) @(posedge clk_sys_in);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wait_idle();
      do apb(1'b0, ADCOC_H_STATUS, 32'h0);
      while (rd[ADCOC_ST_BUSY] !== 1'b0 || rd[ADCOC_ST_SETTLE] !== 1'b0);
   endtask : wait_idle
   task dev_wr(input logic [3:0] a, input logic [23:0] v);
      apb(1'b1, ADCOC_H_WDATA, {8'h00, v});
      apb(1'b1, ADCOC_H_CMD, {28'h0, a});
      wait_idle();
   endtask : dev_wr
   task dev_rd(input logic [3:0] a);
      apb(1'b1, ADCOC_H_CMD, {23'h0, 1'b1, 4'h0, a});
      wait_idle();
      apb(1'b0, ADCOC_H_RDATA, 32'h0);
   endtask : dev_rd
   task sample(input logic s, input logic [23:0] r);
      @(posedge clk_sys_in);
      raw_valid_in <= 1'b1;
      raw_sel_in <= s;
      raw_data_in <= r;
      @(posedge clk_sys_in);
      raw_valid_in <= 1'b0;
      @(posedge clk_sys_in);
      check("out_valid", {31'h0, out_valid_out}, 32'h1);
   endtask : sample
   initial begin
      {rst_n_in, psel, penable, pwrite, cal_load_in, cal_sel_in, raw_valid_in, raw_sel_in} = 8'h00;
      {paddr, pwdata, cal_value_in, raw_data_in} = 88'h0;
      int_clk_run_in = 1'b1;
      {fail_count, tests_run} = 64'h0;
      repeat (10) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      check("sleep_reset", {31'h0, auto_sleep_out}, 32'h1);
      dev_rd(ADCOC_ADDR_OFS_A);
      check("ofs_a_reset", rd, 32'h0);
      dev_rd(ADCOC_ADDR_OFS_B);
      check("ofs_b_reset", rd, 32'h0);
      dev_wr(ADCOC_ADDR_OFS_A, 24'h123456);
      check("sleep_refused", {31'h0, rd[ADCOC_ST_REFUSED]}, 32'h1);
      apb(1'b1, ADCOC_H_STATUS, 32'h0);
      dev_wr(ADCOC_ADDR_OPT0, 24'h000000);
      check("sleep_clear", {31'h0, auto_sleep_out}, 32'h0);
      $display("reset and sleep test done");
      for (i = 0; i < 4; i++) begin
         dev_wr(ra[i], rc[i]);
         dev_rd(ra[i]);
         check("readback", rd, {8'h00, rc[i]});
         sample(ra[i][0], rr[i]);
         check("corrected", {8'h00, out_data_out}, {8'h00, re[i]});
      end
      $display("row test done");
      // A command inside the settle gap must be turned away.
      apb(1'b1, ADCOC_H_STATUS, 32'h0);
      apb(1'b1, ADCOC_H_CMD, {28'h0, ADCOC_ADDR_OFS_A});
      do apb(1'b0, ADCOC_H_STATUS, 32'h0);
      while (rd[ADCOC_ST_SETTLE] !== 1'b1);
      apb(1'b1, ADCOC_H_CMD, {28'h0, ADCOC_ADDR_OFS_B});
      wait_idle();
      check("gap_refused", {31'h0, rd[ADCOC_ST_REFUSED]}, 32'h1);
      $display("settle test done");
      @(posedge clk_sys_in);
      cal_load_in <= 1'b1;
      cal_value_in <= 24'hABCDEF;
      @(posedge clk_sys_in);
      cal_load_in <= 1'b0;
      dev_rd(ADCOC_ADDR_OFS_A);
      check("cal_load", rd, 32'h00ABCDEF);
      dev_wr(ADCOC_ADDR_OFS_A, 24'h000777);
      dev_rd(ADCOC_ADDR_OFS_A);
      check("write_after_cal", rd, 32'h00000777);
      $display("calibration test done");
      int_clk_run_in <= 1'b0;
      apb(1'b1, ADCOC_H_STATUS, 32'h0);
      dev_wr(ADCOC_ADDR_OFS_B, 24'h000111);
      check("clock_refused", {31'h0, rd[ADCOC_ST_REFUSED]}, 32'h1);
      dev_rd(ADCOC_ADDR_OFS_B);
      check("ofs_b_kept", rd, 32'h00FFFFF0);
      int_clk_run_in <= 1'b1;
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped", {31'h0, err}, 32'h1);
      $display("refusal test done");
      @(posedge clk_sys_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      dev_rd(ADCOC_ADDR_OFS_A);
      check("ofs_a_rereset", rd, 32'h0);
      $display("second reset test done");
      give_verdict();
   end
endmodule : testbench
`default_nettype wire

// ---- verilog/adcoc_coef_cell.sv ----
// One offset coefficient register with variant-dependent bit placement.
`timescale 1ns/1ps
`default_nettype none
module adcoc_coef_cell
   import adcoc_pkg::*;
#(
   parameter int RES_BITS = 24
) (
   input wire logic clk_sys_in, // System clock.
   input wire logic rst_n_in, // Synchronous reset, active low.
   input wire logic cal_load_in, // Calibration result strobe.
   input wire logic [RES_BITS-1:0] cal_value_in, // Calibration coefficient.
   input wire logic wr_in, // Serial write strobe.
   input wire logic [23:0] wr_image_in, // Written 24-bit register image.
   output logic signed [23:0] coef_out, // Sign-extended coefficient.
   output logic [23:0] image_out // Register image as read back.
);
   logic [RES_BITS-1:0] coef_q;
   logic [RES_BITS-1:0] wr_field;

   generate
      if (RES_BITS == 20) begin : g_mid
         assign wr_field = wr_image_in[23:4];
         assign image_out = {coef_q, 4'h0};
      end else if (RES_BITS == 16) begin : g_low
         assign wr_field = wr_image_in[15:0];
         assign image_out = 24'($signed(coef_q));
      end else begin : g_high
         assign wr_field = wr_image_in[RES_BITS-1:0];
         assign image_out = 24'(coef_q);
      end
   endgenerate

   assign coef_out = 24'($signed(coef_q));

   // A serial write in the same cycle as a calibration result wins, being the later intent.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         coef_q <= RES_BITS'(ADCOC_OFS_RESET);
      end else if (wr_in) begin
         coef_q <= wr_field;
      end else if (cal_load_in) begin
         coef_q <= cal_value_in;
      end
   end
endmodule : adcoc_coef_cell
`default_nettype wire

// ---- verilog/adcoc_device.sv ----
// Converter end: serial slave, offset registers and offset removal.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adcoc_device
   import adcoc_pkg::*;
#(
   parameter int RES_BITS = 24
) (
   input wire logic clk_sys_in, // System clock.
   input wire logic rst_n_in, // Synchronous reset, active low.
   adcoc_link_if.device link, // Serial link to host.
   input wire logic int_clk_run_in, // Internal converter clock is running.
   input wire logic cal_load_in, // Calibration coefficient ready.
   input wire logic cal_sel_in, // Calibration target: 0 = a, 1 = b.
   input wire logic [RES_BITS-1:0] cal_value_in, // Calibration coefficient.
   input wire logic raw_valid_in, // Raw sample strobe.
   input wire logic [RES_BITS-1:0] raw_data_in, // Raw signed sample.
   input wire logic raw_sel_in, // Offset to apply: 0 = a, 1 = b.
   output logic out_valid_out, // Corrected sample strobe.
   output logic [RES_BITS-1:0] out_data_out, // Corrected signed sample.
   output logic auto_sleep_out // Automatic sleep enable bit.
);
   logic sck_prev_q;
   logic sdo_q;
   logic clk_act_q;
   logic [5:0] bit_cnt_q;
   logic [7:0] cmd_q;
   logic [22:0] data_q;
   logic [23:0] rd_shift_q;
   logic automatic_sleep_enable_q;
   logic fall;
   logic rise;
   logic [7:0] cmd_full;
   logic [23:0] wr_image;
   logic [1:0] wr_hit;
   logic [1:0] cal_hit;
   logic signed [23:0] coef [2];
   logic [23:0] image [2];
   logic [23:0] rd_image;
   logic signed [24:0] diff;
   logic signed [24:0] max_val;
   logic signed [24:0] min_val;
   logic valid_q;
   logic [RES_BITS-1:0] data_out_q;

   // ---------------------------------------------------------------
   // Serial slave
   // ---------------------------------------------------------------
   // Input bits are taken on the falling clock edge; the first output bit is driven on the falling edge ending the command byte, the rest change on rising edges.
   assign fall = sck_prev_q & ~link.sck & ~link.csb_n;
   assign rise = ~sck_prev_q & link.sck & ~link.csb_n;
   assign cmd_full = {cmd_q[6:0], link.sdi};
   assign wr_image = {data_q, link.sdi};

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sck_prev_q <= 1'b1;
      end else begin
         sck_prev_q <= link.sck;
      end
   end

   // Deasserted chip select clears the frame, so every frame starts with a command byte.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in || link.csb_n) begin
         bit_cnt_q <= 6'h00;
         cmd_q <= 8'h00;
         data_q <= 23'h000000;
      end else if (fall && bit_cnt_q < 6'(ADCOC_FRAME_BITS)) begin
         bit_cnt_q <= bit_cnt_q + 6'h01;
         if (bit_cnt_q < 6'(ADCOC_CMD_BITS)) begin
            cmd_q <= cmd_full;
         end else begin
            data_q <= wr_image[22:0];
         end
      end
   end

   always_comb begin
      case (cmd_full[3:0])
         ADCOC_ADDR_OFS_A: rd_image = image[0];
         ADCOC_ADDR_OFS_B: rd_image = image[1];
         ADCOC_ADDR_OPT0: rd_image = {23'h000000, automatic_sleep_enable_q};
         default: rd_image = 24'h000000;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         rd_shift_q <= 24'h000000;
         sdo_q <= 1'b0;
      end else if (fall && bit_cnt_q == 6'(ADCOC_CMD_BITS - 1)) begin
         sdo_q <= rd_image[23];
         rd_shift_q <= {rd_image[22:0], 1'b0};
      end else if (rise && bit_cnt_q > 6'(ADCOC_CMD_BITS)) begin
         sdo_q <= rd_shift_q[23];
         rd_shift_q <= {rd_shift_q[22:0], 1'b0};
      end
   end

   // The last data bit completes a write; the command's read bit suppresses it.
   logic frame_wr;
   assign frame_wr = fall && bit_cnt_q == 6'(ADCOC_FRAME_BITS - 1) && !cmd_q[ADCOC_CMD_READ_BIT];

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         automatic_sleep_enable_q <= ADCOC_OPT0_SLEEP_RESET;
      end else if (frame_wr && cmd_q[3:0] == ADCOC_ADDR_OPT0) begin
         automatic_sleep_enable_q <= wr_image[ADCOC_OPT0_SLEEP_BIT];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         clk_act_q <= 1'b0;
      end else begin
         clk_act_q <= int_clk_run_in;
      end
   end

   assign link.sdo = sdo_q;
   assign link.clk_active = clk_act_q;
   assign auto_sleep_out = automatic_sleep_enable_q;

   // ---------------------------------------------------------------
   // Coefficient registers
   // ---------------------------------------------------------------
   assign wr_hit[0] = frame_wr && cmd_q[3:0] == ADCOC_ADDR_OFS_A;
   assign wr_hit[1] = frame_wr && cmd_q[3:0] == ADCOC_ADDR_OFS_B;
   assign cal_hit[0] = cal_load_in && !cal_sel_in;
   assign cal_hit[1] = cal_load_in && cal_sel_in;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_coef
         adcoc_coef_cell #(
            .RES_BITS(RES_BITS)
         ) u_cell (
            .clk_sys_in(clk_sys_in),
            .rst_n_in(rst_n_in),
            .cal_load_in(cal_hit[gi]),
            .cal_value_in(cal_value_in),
            .wr_in(wr_hit[gi]),
            .wr_image_in(wr_image),
            .coef_out(coef[gi]),
            .image_out(image[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Offset removal
   // ---------------------------------------------------------------
   // The difference saturates at the sample range so a large offset cannot wrap the sign.
   assign max_val = 25'(($signed(25'h1) <<< (RES_BITS - 1)) - 25'sh1);
   assign min_val = -max_val - 25'sh1;
   assign diff = 25'($signed(raw_data_in)) - 25'(coef[raw_sel_in]);

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         valid_q <= 1'b0;
         data_out_q <= '0;
      end else begin
         valid_q <= raw_valid_in;
         if (raw_valid_in) begin
            if (diff > max_val) begin
               data_out_q <= max_val[RES_BITS-1:0];
            end else if (diff < min_val) begin
               data_out_q <= min_val[RES_BITS-1:0];
            end else begin
               data_out_q <= diff[RES_BITS-1:0];
            end
         end
      end
   end

   assign out_valid_out = valid_q;
   assign out_data_out = data_out_q;
endmodule : adcoc_device
`default_nettype wire

// ---- verilog/adcoc_host.sv ----
// Host end: APB-programmed serial master for the offset registers.
`timescale 1ns/1ps
`default_nettype none
module adcoc_host
   import adcoc_pkg::*;
(
   input wire logic clk_sys_in, // System clock.
   input wire logic rst_n_in, // Synchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB direction.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   adcoc_link_if.host link // Serial link to device.
);
   adcoc_hstate_t state_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic sck_q;
   logic csb_n_q;
   logic sdi_q;
   logic [31:0] tx_q;
   logic [23:0] rx_q;
   logic [23:0] wdata_q;
   logic [5:0] bit_cnt_q;
   logic [9:0] half_q;
   logic [9:0] gap_q;
   logic refused_q;
   logic sleep_shadow_q;
   logic ofs_wr_q;
   logic setup;
   logic access;
   logic cmd_wr;
   logic is_read;
   logic is_ofs;
   logic allowed;
   logic mapped;

   assign setup = psel && !penable && !pready_q;
   // Writes act only at the edge where the master sees pready high, so a master that holds the access phase longer
   // still gets exactly one write.
   assign access = psel && penable && pready_q;
   assign cmd_wr = access && pwrite && paddr == ADCOC_H_CMD;
   assign is_read = pwdata[ADCOC_H_CMD_READ_BIT];
   assign is_ofs = pwdata[3:0] == ADCOC_ADDR_OFS_A || pwdata[3:0] == ADCOC_ADDR_OFS_B;
   // Offset writes need a running device clock and automatic sleep off.
   assign allowed = state_q == ADCOC_H_IDLE && (is_read || !is_ofs || (link.clk_active && !sleep_shadow_q));
   assign mapped = paddr == ADCOC_H_CMD || paddr == ADCOC_H_WDATA || paddr == ADCOC_H_RDATA || paddr == ADCOC_H_STATUS;

   // ---------------------------------------------------------------
   // APB slave: read data is fetched in setup, writes land when the access completes
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
         wdata_q <= 24'h000000;
         refused_q <= 1'b0;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup && !mapped;
         if (access && pwrite && paddr == ADCOC_H_WDATA) begin
            wdata_q <= pwdata[23:0];
         end
         if (cmd_wr && !allowed) begin
            refused_q <= 1'b1;
         end else if (access && pwrite && paddr == ADCOC_H_STATUS) begin
            refused_q <= 1'b0;
         end
         if (setup && !pwrite) begin
            case (paddr)
               ADCOC_H_RDATA: prdata_q <= {8'h00, rx_q};
               ADCOC_H_STATUS: prdata_q <= {28'h0000000, sleep_shadow_q, state_q == ADCOC_H_GAP, refused_q,
                                            state_q != ADCOC_H_IDLE};
               ADCOC_H_WDATA: prdata_q <= {8'h00, wdata_q};
               default: prdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Serial master: clock idles high, data changes on rising edges
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         state_q <= ADCOC_H_IDLE;
         sck_q <= 1'b1;
         csb_n_q <= 1'b1;
         sdi_q <= 1'b0;
         tx_q <= 32'h00000000;
         rx_q <= 24'h000000;
         bit_cnt_q <= 6'h00;
         half_q <= 10'h000;
         gap_q <= 10'h000;
         sleep_shadow_q <= ADCOC_OPT0_SLEEP_RESET;
         ofs_wr_q <= 1'b0;
      end else begin
         case (state_q)
            ADCOC_H_IDLE: begin
               if (cmd_wr && allowed) begin
                  state_q <= ADCOC_H_XFER;
                  csb_n_q <= 1'b0;
                  tx_q <= {is_read, 3'h0, pwdata[3:0], wdata_q};
                  sdi_q <= is_read;
                  bit_cnt_q <= 6'h00;
                  half_q <= 10'(ADCOC_SCK_HALF_CYCLES - 1);
                  ofs_wr_q <= !is_read && is_ofs;
                  if (!is_read && pwdata[3:0] == ADCOC_ADDR_OPT0) begin
                     sleep_shadow_q <= wdata_q[ADCOC_OPT0_SLEEP_BIT];
                  end
               end
            end
            ADCOC_H_XFER: begin
               if (half_q != 10'h000) begin
                  half_q <= half_q - 10'h001;
               end else begin
                  half_q <= 10'(ADCOC_SCK_HALF_CYCLES - 1);
                  if (sck_q) begin
                     sck_q <= 1'b0;
                     rx_q <= {rx_q[22:0], link.sdo};
                     bit_cnt_q <= bit_cnt_q + 6'h01;
                  end else if (bit_cnt_q == 6'(ADCOC_FRAME_BITS)) begin
                     sck_q <= 1'b1;
                     csb_n_q <= 1'b1;
                     gap_q <= 10'(ADCOC_SETTLE_CYCLES - 1);
                     state_q <= ofs_wr_q ? ADCOC_H_GAP : ADCOC_H_IDLE;
                  end else begin
                     sck_q <= 1'b1;
                     tx_q <= {tx_q[30:0], 1'b0};
                     sdi_q <= tx_q[30];
                  end
               end
            end
            ADCOC_H_GAP: begin
               // Any new frame is refused until the settling gap has run out.
               if (gap_q == 10'h000) begin
                  state_q <= ADCOC_H_IDLE;
               end else begin
                  gap_q <= gap_q - 10'h001;
               end
            end
            default: state_q <= ADCOC_H_IDLE;
         endcase
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign link.sck = sck_q;
   assign link.csb_n = csb_n_q;
   assign link.sdi = sdi_q;
endmodule : adcoc_host
`default_nettype wire

// ---- verilog/adcoc_link_if.sv ----
// Serial link between host controller and offset coefficient device.
`timescale 1ns/1ps
`default_nettype none
interface adcoc_link_if;
   logic sck;
   logic csb_n;
   logic sdi;
   logic sdo;
   logic clk_active;
   modport device (input sck, input csb_n, input sdi, output sdo, output clk_active);
   modport host (output sck, output csb_n, output sdi, input sdo, input clk_active);
endinterface : adcoc_link_if
`default_nettype wire

// ---- verilog/adcoc_pkg.sv ----
// Shared constants for the offset coefficient register block and its host.
// Function
// - Two RW offset registers, 0xC/0xD, reset zero.
// - Register holds last of calibration or write.
// - Low variant: 16-bit signed in bits 15:0.
// - Middle variant: 20-bit in 23:4, low four unimplemented.
// - High variant: 24-bit signed in bits 23:0.
// - Coefficients are sign-extended two's complement.
// - Host writes offsets only while clock runs.
// - Host clears automatic sleep before offset writes; the host does not clear it but refuses offset writes while sleep is set.
// - Host waits 10 us after each offset write.
`default_nettype none
package adcoc_pkg;
   // ---------------------------------------------------------------
   // Device register map and serial frame
   // ---------------------------------------------------------------
   localparam logic [3:0] ADCOC_ADDR_OFS_A = 4'hC;
   localparam logic [3:0] ADCOC_ADDR_OFS_B = 4'hD;
   localparam logic [3:0] ADCOC_ADDR_OPT0 = 4'h1;
   localparam int ADCOC_OPT0_SLEEP_BIT = 0;
   localparam logic [23:0] ADCOC_OFS_RESET = 24'h000000;
   localparam logic ADCOC_OPT0_SLEEP_RESET = 1'b1;
   localparam int ADCOC_CMD_READ_BIT = 7;
   localparam int ADCOC_CMD_BITS = 8;
   localparam int ADCOC_DATA_BITS = 24;
   localparam int ADCOC_FRAME_BITS = ADCOC_CMD_BITS + ADCOC_DATA_BITS;
   // ---------------------------------------------------------------
   // Host register map (APB byte addresses) and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] ADCOC_H_CMD = 8'h00;
   localparam logic [7:0] ADCOC_H_WDATA = 8'h04;
   localparam logic [7:0] ADCOC_H_RDATA = 8'h08;
   localparam logic [7:0] ADCOC_H_STATUS = 8'h0C;
   localparam int ADCOC_H_CMD_READ_BIT = 8;
   localparam int ADCOC_ST_BUSY = 0;
   localparam int ADCOC_ST_REFUSED = 1;
   localparam int ADCOC_ST_SETTLE = 2;
   localparam int ADCOC_ST_SLEEP = 3;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int ADCOC_CLK_PERIOD_NS = 10;
   localparam int ADCOC_SETTLE_US = 10;
   localparam int ADCOC_SETTLE_CYCLES = (ADCOC_SETTLE_US * 1000 + ADCOC_CLK_PERIOD_NS - 1) / ADCOC_CLK_PERIOD_NS;
   localparam int ADCOC_SCK_HALF_CYCLES = 4;
   typedef enum logic [1:0] {
      ADCOC_H_IDLE = 2'b00,
      ADCOC_H_XFER = 2'b01,
      ADCOC_H_GAP = 2'b10
   } adcoc_hstate_t;
endpackage : adcoc_pkg
`default_nettype wire
